// >>> hw/afc_consts.vh
`ifndef AFC_CONSTS_VH
`define AFC_CONSTS_VH
// register byte offsets
`define AFC_OFS_STATUS 8'h00
`define AFC_OFS_MODE 8'h04
`define AFC_OFS_CONFIG 8'h08
`define AFC_OFS_IO 8'h0C
`define AFC_OFS_DATA 8'h10
`define AFC_OFS_OFFSET 8'h14
`define AFC_OFS_FULLSC 8'h18
// status fields
`define AFC_ST_NRDY 0
`define AFC_ST_ERR 1
`define AFC_ST_NOREF 2
// mode fields
`define AFC_MD_LO 0
`define AFC_MD_HI 2
`define AFC_MD_CHOP 3
// config fields
`define AFC_CF_BURN 0
`define AFC_CF_REFDET 1
`define AFC_CF_REF_LO 2
`define AFC_CF_REF_HI 3
`define AFC_CF_BIAS_LO 4
`define AFC_CF_BIAS_HI 5
`define AFC_CF_BOOST 6
`define AFC_CF_IN_LO 7
`define AFC_CF_IN_HI 9
`define AFC_CF_GAIN_LO 10
`define AFC_CF_GAIN_HI 12
// io fields
`define AFC_IO_MAG_LO 0
`define AFC_IO_MAG_HI 1
`define AFC_IO_STEER 2
// operating modes
`define AFC_MODE_CONT 3'h0
`define AFC_MODE_SINGLE 3'h1
`define AFC_MODE_IDLE 3'h2
`define AFC_MODE_PDOWN 3'h3
`define AFC_MODE_INT_ZERO 3'h4
`define AFC_MODE_INT_FULL 3'h5
`define AFC_MODE_SYS_ZERO 3'h6
`define AFC_MODE_SYS_FULL 3'h7
// reference select codes
`define AFC_REF_EXT_A 2'h0
`define AFC_REF_EXT_B 2'h1
`define AFC_REF_INT 2'h2
// monitor input code, gain codes
`define AFC_IN_MONITOR 3'h7
`define AFC_GAIN_1 3'h0
`define AFC_GAIN_128 3'h7
// reset values, mid-scale offset and full-scale code
`define AFC_MODE_RST 4'h0
`define AFC_CONFIG_RST 13'h0000
`define AFC_IO_RST 3'h0
`define AFC_COEF_RST 24'h80_0000
`define AFC_MID_CODE 27'h080_0000
`define AFC_FULL_CODE 24'hFF_FFFF
// full-scale coefficient shift
`define AFC_GAIN_SHIFT 23
// conversion cycles per calibration
`define AFC_CYC_ONE 3'h1
`define AFC_CYC_TWO 3'h2
`define AFC_CYC_FOUR 3'h4
// serial ones that reset the block
`define AFC_RESET_ONES 32
`endif

// >>> hw/afc_ones_detect.v
`timescale 1ns/1ps
`include "afc_consts.vh"
// counts serial ones while selected
module afc_ones_detect #(
    parameter ONES = `AFC_RESET_ONES,
    parameter CW = 6
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // synchronised serial pins
    input wire sclk_s,
    input wire cs_n_s,
    input wire din_s,
    // one-cycle reset request
    output reg hit
);
    reg sclk_d;
    reg [CW-1:0] count;

    // edges found on the synchronised copy; idle clock is high
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sclk_d <= 1'b1;
            count <= {CW{1'b0}};
            hit <= 1'b0;
        end
        else
        begin
            sclk_d <= sclk_s;
            hit <= 1'b0;
            if (sclk_s && !sclk_d && !cs_n_s)
            begin
                if (!din_s)
                    count <= {CW{1'b0}}; // RL20
                else if (count == ONES[CW-1:0] - 1'b1)
                begin
                    count <= {CW{1'b0}};
                    hit <= 1'b1; // RL20
                end
                else
                    count <= count + 1'b1; // RL20
            end
        end
    end
endmodule

// >>> hw/afc_frontend_ctrl.v
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "afc_consts.vh"
// Notes on behaviour
// RL1: burnout bit switches both 100 nA currents
// RL2: reference check only enabled and external reference
// RL3: low or open reference sets absent flag
// RL4: absent reference forces results to all ones
// RL5: absent reference in calibration blocks coefficients, errors
// RL6: 32 serial ones reset logic and registers
// RL7: host waits 500 us before register access
// RL8: power-up reset performs the same full reset
// RL9: monitor setting converts supply/6 on internal reference
// RL10: mode field starts four calibration kinds
// RL11: subtract offset, multiply full scale, then store
// RL12: calibration end updates coefficient, ready, idle
// RL13: excitation enable, steering and magnitude select
// RL14: bias drives negative pin, pairs one to three
// RL15: boost bit raises bias generator current
// RL16: reference select, internal never on pins
// RL17: offset calibration one cycle, two chopped
// RL18: no internal full scale at gain 128
// RL19: ready line high throughout calibration
// RL20: count serial ones, zero clears, threshold resets
// RL21: error held until next calibration or conversion
module afc_frontend_ctrl (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // serial pins to and from the host
    input wire sclk,
    input wire cs_n,
    input wire din,
    output wire dout_rdy_o,
    output wire dout_rdy_oe_n,
    // modulator side
    input wire raw_valid,
    input wire [23:0] raw_data,
    input wire ref_low,
    input wire ref_open,
    output reg mod_reset,
    output reg mod_run,
    output reg cal_zero_int,
    output reg cal_full_int,
    // analog switch controls
    output reg burnout_source_en,
    output reg burnout_sink_en,
    output reg excite_pin_a,
    output reg excite_pin_b,
    output reg [1:0] excite_mag,
    output reg [2:0] mid_supply_pair_en,
    output reg bias_boost,
    output reg ext_ref_pair_a,
    output reg ext_ref_pair_b,
    output reg int_ref_en,
    output reg supply_monitor_en,
    output reg [2:0] input_select
);
    // two-stage synchronisers for pins
    reg [4:0] sync1;
    reg [4:0] sync2;
    wire sclk_s = sync2[0];
    wire cs_n_s = sync2[1];
    wire din_s = sync2[2];
    wire ref_low_s = sync2[3];
    wire ref_open_s = sync2[4];

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1 <= 5'h03;
            sync2 <= 5'h03;
        end
        else
        begin
            sync1 <= {ref_open, ref_low, din, cs_n, sclk};
            sync2 <= sync1;
        end
    end

    // serial reset pattern detector
    wire soft_rst;

    afc_ones_detect #(
        .ONES(`AFC_RESET_ONES),
        .CW(6)
    ) u_ones (
        .hclk(hclk),
        .hresetn(hresetn),
        .sclk_s(sclk_s),
        .cs_n_s(cs_n_s),
        .din_s(din_s),
        .hit(soft_rst)
    );

    // registers
    reg [3:0] mode;
    reg [12:0] cfg;
    reg [2:0] io;
    reg [23:0] data;
    reg [23:0] offset_coef;
    reg [23:0] fullsc_coef;
    reg not_ready;
    reg err;
    reg ref_lost;
    reg [2:0] cyc_left;
    reg rdy_line;

    wire [2:0] op_mode = mode[`AFC_MD_HI:`AFC_MD_LO];
    wire chop = mode[`AFC_MD_CHOP];
    wire [1:0] ref_sel = cfg[`AFC_CF_REF_HI:`AFC_CF_REF_LO];
    wire [2:0] in_sel = cfg[`AFC_CF_IN_HI:`AFC_CF_IN_LO];
    wire [2:0] gain = cfg[`AFC_CF_GAIN_HI:`AFC_CF_GAIN_LO];

    // monitor always runs on the internal reference
    wire monitor = (in_sel == `AFC_IN_MONITOR); // RL9
    wire [1:0] eff_ref = monitor ? `AFC_REF_INT : ref_sel; // RL9
    wire ext_sel = (eff_ref == `AFC_REF_EXT_A) || (eff_ref == `AFC_REF_EXT_B);
    wire check_on = cfg[`AFC_CF_REFDET] && ext_sel; // RL2
    wire absent_ref = check_on && (ref_low_s || ref_open_s); // RL3

    // decoding shared by writes and sequencer
    function is_cal;
        input [2:0] m;
        begin
            is_cal = m[2];
        end
    endfunction

    function [2:0] cal_cycles;
        input [2:0] m;
        input ch;
        input [2:0] g;
        begin
            if (m == `AFC_MODE_INT_FULL && g != `AFC_GAIN_1)
                cal_cycles = ch ? `AFC_CYC_FOUR : `AFC_CYC_TWO;
            else
                cal_cycles = ch ? `AFC_CYC_TWO : `AFC_CYC_ONE; // RL17
        end
    endfunction

    // ahb address phase capture
    reg ph_valid;
    reg ph_write;
    reg [7:0] ph_addr;
    wire take = hsel && hready && htrans[1];

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    function [31:0] read_mux;
        input [7:0] a;
        input [2:0] st;
        input [3:0] md;
        input [12:0] cf;
        input [2:0] iv;
        input [23:0] dt;
        input [23:0] oc;
        input [23:0] fc;
        begin
            case (a)
                `AFC_OFS_STATUS: read_mux = {29'h0000_0000, st};
                `AFC_OFS_MODE: read_mux = {28'h000_0000, md};
                `AFC_OFS_CONFIG: read_mux = {19'h0_0000, cf};
                `AFC_OFS_IO: read_mux = {29'h0000_0000, iv};
                `AFC_OFS_DATA: read_mux = {8'h00, dt};
                `AFC_OFS_OFFSET: read_mux = {8'h00, oc};
                `AFC_OFS_FULLSC: read_mux = {8'h00, fc};
                default: read_mux = 32'h0000_0000;
            endcase
        end
    endfunction

    wire [2:0] status = {absent_ref, err, not_ready};

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            ph_valid <= take;
            ph_write <= hwrite;
            ph_addr <= haddr;
            if (take && !hwrite)
                hrdata <= read_mux(haddr, status, mode, cfg, io, data, offset_coef, fullsc_coef);
        end
    end

    wire wr = ph_valid && ph_write;
    wire rd_data = take && !hwrite && (haddr == `AFC_OFS_DATA);
    wire mode_wr = wr && (ph_addr == `AFC_OFS_MODE);
    wire [2:0] new_mode = hwdata[`AFC_MD_HI:`AFC_MD_LO];
    // internal full scale refused at top gain
    wire refuse = (new_mode == `AFC_MODE_INT_FULL) && (gain == `AFC_GAIN_128); // RL18
    wire cal_start = mode_wr && is_cal(new_mode) && !refuse; // RL10
    wire conv_start = mode_wr && (new_mode == `AFC_MODE_CONT || new_mode == `AFC_MODE_SINGLE);

    // result correction: offset removed first, then full-scale gain
    wire signed [24:0] diff = $signed({1'b0, raw_data}) - $signed({1'b0, offset_coef}); // RL11
    wire signed [49:0] prod = diff * $signed({1'b0, fullsc_coef}); // RL11
    wire signed [26:0] scaled = prod[49:`AFC_GAIN_SHIFT] + $signed(`AFC_MID_CODE);
    reg [23:0] corrected;

    always @*
    begin
        if (scaled < 0)
            corrected = 24'h00_0000;
        else if (scaled > $signed({3'b000, `AFC_FULL_CODE}))
            corrected = `AFC_FULL_CODE;
        else
            corrected = scaled[23:0];
    end

    wire converting = (op_mode == `AFC_MODE_CONT) || (op_mode == `AFC_MODE_SINGLE);
    wire calibrating = is_cal(op_mode);
    wire cal_last = calibrating && raw_valid && (cyc_left == 3'h1);

    // register file, sequencer and ready line; serial pattern resets all
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode <= `AFC_MODE_RST; // RL8
            cfg <= `AFC_CONFIG_RST;
            io <= `AFC_IO_RST;
            data <= 24'h00_0000;
            offset_coef <= `AFC_COEF_RST;
            fullsc_coef <= `AFC_COEF_RST;
            not_ready <= 1'b1;
            err <= 1'b0;
            ref_lost <= 1'b0;
            cyc_left <= 3'h0;
            rdy_line <= 1'b1;
        end
        else if (soft_rst)
        begin
            mode <= `AFC_MODE_RST; // RL6
            cfg <= `AFC_CONFIG_RST;
            io <= `AFC_IO_RST;
            data <= 24'h00_0000;
            offset_coef <= `AFC_COEF_RST;
            fullsc_coef <= `AFC_COEF_RST;
            not_ready <= 1'b1;
            err <= 1'b0;
            ref_lost <= 1'b0;
            cyc_left <= 3'h0;
            rdy_line <= 1'b1;
        end
        else
        begin
            // software writes
            if (wr && ph_addr == `AFC_OFS_CONFIG)
                cfg <= hwdata[12:0];
            if (wr && ph_addr == `AFC_OFS_IO)
                io <= hwdata[2:0];
            if (wr && ph_addr == `AFC_OFS_OFFSET)
                offset_coef <= hwdata[23:0];
            if (wr && ph_addr == `AFC_OFS_FULLSC)
                fullsc_coef <= hwdata[23:0];
            if (mode_wr && !refuse)
                mode <= hwdata[3:0];
            if (rd_data)
                rdy_line <= 1'b1;
            // error held until a new calibration or conversion starts;
            // a fresh error in that cycle wins over a conversion-start clear; a calibration start's clear wins
            if (cal_start || conv_start)
                err <= 1'b0; // RL21
            if (cal_start)
            begin
                cyc_left <= cal_cycles(new_mode, hwdata[`AFC_MD_CHOP], gain); // RL17
                ref_lost <= 1'b0;
                not_ready <= 1'b1;
                rdy_line <= 1'b1; // RL19
            end
            else if (calibrating)
            begin
                if (absent_ref)
                begin
                    ref_lost <= 1'b1;
                    err <= 1'b1; // RL5
                end
                if (raw_valid)
                    cyc_left <= cyc_left - 1'b1;
                if (cal_last)
                begin
                    if (!ref_lost && !absent_ref)
                    begin
                        if (op_mode == `AFC_MODE_INT_ZERO || op_mode == `AFC_MODE_SYS_ZERO)
                            offset_coef <= raw_data; // RL12
                        else
                            fullsc_coef <= raw_data; // RL12
                    end
                    not_ready <= 1'b0; // RL12
                    rdy_line <= 1'b0; // RL12
                    mode <= {chop, `AFC_MODE_IDLE}; // RL12
                end
            end
            else if (converting && raw_valid)
            begin
                data <= absent_ref ? `AFC_FULL_CODE : corrected; // RL4 RL11
                not_ready <= 1'b0;
                rdy_line <= 1'b0;
                if (op_mode == `AFC_MODE_SINGLE)
                    mode <= {chop, `AFC_MODE_IDLE};
            end
            if (conv_start)
                not_ready <= 1'b1;
        end
    end

    // drives only while selected
    assign dout_rdy_o = rdy_line; // RL12 RL19
    assign dout_rdy_oe_n = cs_n_s;

    // modulator and analog switch controls, registered
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mod_reset <= 1'b1;
            mod_run <= 1'b0;
            cal_zero_int <= 1'b0;
            cal_full_int <= 1'b0;
            burnout_source_en <= 1'b0;
            burnout_sink_en <= 1'b0;
            excite_pin_a <= 1'b0;
            excite_pin_b <= 1'b0;
            excite_mag <= 2'h0;
            mid_supply_pair_en <= 3'h0;
            bias_boost <= 1'b0;
            ext_ref_pair_a <= 1'b0;
            ext_ref_pair_b <= 1'b0;
            int_ref_en <= 1'b0;
            supply_monitor_en <= 1'b0;
            input_select <= 3'h0;
        end
        else
        begin
            mod_reset <= soft_rst; // RL6
            mod_run <= converting || calibrating;
            cal_zero_int <= (op_mode == `AFC_MODE_INT_ZERO);
            cal_full_int <= (op_mode == `AFC_MODE_INT_FULL);
            burnout_source_en <= cfg[`AFC_CF_BURN]; // RL1
            burnout_sink_en <= cfg[`AFC_CF_BURN]; // RL1
            // both matched sources steered together to one pin
            excite_pin_a <= (io[`AFC_IO_MAG_HI:`AFC_IO_MAG_LO] != 2'h0) && !io[`AFC_IO_STEER]; // RL13
            excite_pin_b <= (io[`AFC_IO_MAG_HI:`AFC_IO_MAG_LO] != 2'h0) && io[`AFC_IO_STEER]; // RL13
            excite_mag <= io[`AFC_IO_MAG_HI:`AFC_IO_MAG_LO]; // RL13
            // field 1..3 picks pair one..three, zero is off
            mid_supply_pair_en <= cfg[`AFC_CF_BIAS_HI:`AFC_CF_BIAS_LO] == 2'h0 ? 3'h0 :
                3'h1 << (cfg[`AFC_CF_BIAS_HI:`AFC_CF_BIAS_LO] - 2'h1); // RL14
            bias_boost <= cfg[`AFC_CF_BOOST]; // RL15
            ext_ref_pair_a <= (eff_ref == `AFC_REF_EXT_A); // RL16
            ext_ref_pair_b <= (eff_ref == `AFC_REF_EXT_B); // RL16
            int_ref_en <= !ext_sel; // RL16
            supply_monitor_en <= monitor; // RL9
            input_select <= in_sel;
        end
    end
endmodule

// >>> verif/afc_host_model.sv
`timescale 1ns/1ps
// host side of the serial link; clock runs only in frames
module afc_host_model (
    // serial pins towards the block
    output logic sclk,
    output logic cs_n,
    output logic din
);
    // parked: deselected, clock high
    initial
    begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // n bits msb first, 800 ns per bit, data on the falling edge
    task automatic send(input logic [63:0] bits, input int n);
        cs_n = 1'b0;
        #400;
        for (int i = n - 1; i >= 0; i--)
        begin
            sclk = 1'b0;
            din = bits[i];
            #400;
            sclk = 1'b1;
            #400;
        end
        cs_n = 1'b1;
        // released data line shows the inverse
        din = ~din;
    endtask
endmodule

// >>> verif/afc_frontend_ctrl_monitor.sv
`timescale 1ns/1ps
// switch outputs and bus answers the block must never show
module afc_frontend_ctrl_monitor (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // bus answer
    input wire hreadyout,
    input wire hresp,
    // modulator side
    input wire mod_reset,
    input wire cal_zero_int,
    input wire cal_full_int,
    // analog switches
    input wire burnout_source_en,
    input wire burnout_sink_en,
    input wire excite_pin_a,
    input wire excite_pin_b,
    input wire [1:0] excite_mag,
    input wire [2:0] mid_supply_pair_en,
    input wire ext_ref_pair_a,
    input wire ext_ref_pair_b,
    input wire int_ref_en,
    input wire supply_monitor_en
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // both open-sensor currents switch together
    burn_pair_a: assert property (burnout_source_en == burnout_sink_en)
        else $error("open sensor currents split");
    // sources on exactly one pin when a magnitude is set
    excite_steer_a: assert property (((excite_pin_a | excite_pin_b) == (excite_mag != 2'h0))
        && !(excite_pin_a && excite_pin_b)) else $error("excitation steering wrong");
    bias_onehot_a: assert property ($onehot0(mid_supply_pair_en))
        else $error("mid supply on more than one pair");
    // internal reference never on external pairs
    ref_excl_a: assert property (int_ref_en |-> !ext_ref_pair_a && !ext_ref_pair_b)
        else $error("internal reference on external pair");
    ext_pair_excl_a: assert property (!(ext_ref_pair_a && ext_ref_pair_b))
        else $error("two external references at once");
    monitor_ref_a: assert property (supply_monitor_en |-> int_ref_en)
        else $error("supply monitor without internal reference");
    int_cal_excl_a: assert property (!(cal_zero_int && cal_full_int))
        else $error("two internal calibrations at once");
    // modulator reset is a single pulse
    reset_pulse_a: assert property (mod_reset |=> !mod_reset)
        else $error("modulator reset longer than one cycle");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
endmodule

// >>> verif/adc_frontend_cal_refdet_control_tb_top.sv
`timescale 1ns/1ps
`include "afc_consts.vh"
module adc_frontend_cal_refdet_control_tb_top;
    // stimulus and design outputs
    logic hclk, hresetn, hsel, hwrite, raw_valid, ref_low, ref_open;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, rd;
    logic [23:0] raw_data;
    wire [31:0] hrdata;
    wire hreadyout, hresp, sclk, cs_n, din, dout_rdy_o, dout_rdy_oe_n, mod_reset, mod_run, cal_zero_int, cal_full_int;
    wire burnout_source_en, burnout_sink_en, excite_pin_a, excite_pin_b, bias_boost, ext_ref_pair_a, ext_ref_pair_b;
    wire int_ref_en, supply_monitor_en;
    wire [1:0] excite_mag;
    wire [2:0] mid_supply_pair_en, input_select;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n_modrst = 0;
    // slave ready is bus ready
    afc_frontend_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sclk(sclk), .cs_n(cs_n), .din(din), .dout_rdy_o(dout_rdy_o),
        .dout_rdy_oe_n(dout_rdy_oe_n), .raw_valid(raw_valid), .raw_data(raw_data), .ref_low(ref_low),
        .ref_open(ref_open), .mod_reset(mod_reset), .mod_run(mod_run), .cal_zero_int(cal_zero_int),
        .cal_full_int(cal_full_int), .burnout_source_en(burnout_source_en), .burnout_sink_en(burnout_sink_en),
        .excite_pin_a(excite_pin_a), .excite_pin_b(excite_pin_b), .excite_mag(excite_mag),
        .mid_supply_pair_en(mid_supply_pair_en), .bias_boost(bias_boost), .ext_ref_pair_a(ext_ref_pair_a),
        .ext_ref_pair_b(ext_ref_pair_b), .int_ref_en(int_ref_en), .supply_monitor_en(supply_monitor_en),
        .input_select(input_select));
    afc_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din));
    // 100 ns clock
    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // counts modulator reset pulses
    always @(posedge hclk)
        if (hresetn && mod_reset)
            n_modrst++;
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask
    // waits for ready; a stuck bus ends the run
    task automatic edge_rdy();
        int k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            k++;
            if (k > 20)
            begin
                n_mismatch++;
                stop_test();
            end
            @(posedge hclk);
        end
    endtask
    // one word, entered just after a rising edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        edge_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        edge_rdy();
        rd = hrdata;
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp, m = 32'hFFFF_FFFF);
        ahb(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd & m);
    endtask
    task automatic conv(input logic [23:0] v);
        raw_valid <= 1'b1;
        raw_data <= v;
        @(posedge hclk);
        raw_valid <= 1'b0;
        @(posedge hclk);
    endtask
    task automatic setcfg(input logic [31:0] v);
        ahb(1'b1, `AFC_OFS_CONFIG, v);
        repeat (4) @(posedge hclk);
    endtask
    task automatic wrm(input logic [31:0] v);
        ahb(1'b1, `AFC_OFS_MODE, v);
    endtask
    task automatic t_reset();
        rdc("mode", `AFC_OFS_MODE, 32'h0000_0000);
        rdc("config", `AFC_OFS_CONFIG, 32'h0000_0000);
        rdc("offset", `AFC_OFS_OFFSET, 32'h0080_0000);
        ahb(1'b1, 8'h1C, 32'hFFFF_FFFF);
        rdc("unmapped", 8'h1C, 32'h0000_0000);
    endtask
    // walks config and io codes
    task automatic t_switch();
        logic [12:0] cf;
        logic [1:0] rf;
        logic mon;
        logic [2:0] be;
        logic [16:0] ex;
        for (int i = 0; i < 8; i++)
        begin
            rf = ~i[1:0];
            mon = (i == 7);
            be = (i[1:0] == 2'h0) ? 3'h0 : (3'h1 << (i[1:0] - 2'h1));
            cf = {3'h0, i[2:0], i[0], i[1:0], rf, 1'b0, i[0]};
            ahb(1'b1, `AFC_OFS_CONFIG, {19'h0, cf});
            ahb(1'b1, `AFC_OFS_IO, {29'h0, i[2], i[1:0]});
            repeat (2) @(posedge hclk);
            ex = {i[0], i[0], rf[1] | mon, (rf == 2'h0) & !mon, (rf == 2'h1) & !mon, mon, i[2:0], be, i[0],
                (i[1:0] != 2'h0) & !i[2], (i[1:0] != 2'h0) & i[2], i[1:0]};
            chk("switches", ex, {burnout_source_en, burnout_sink_en, int_ref_en, ext_ref_pair_a, ext_ref_pair_b,
                supply_monitor_en, input_select, mid_supply_pair_en, bias_boost, excite_pin_a, excite_pin_b, excite_mag});
        end
    endtask
    task automatic t_conv();
        setcfg(32'h0000_0002);
        ahb(1'b1, `AFC_OFS_OFFSET, 32'h0080_0010);
        ahb(1'b1, `AFC_OFS_FULLSC, 32'h0040_0000);
        wrm(32'h0000_0000);
        conv(24'h90_0010);
        rdc("corrected data", `AFC_OFS_DATA, 32'h0088_0000);
        ref_low <= 1'b1;
        setcfg(32'h0000_0002);
        rdc("absent flag", `AFC_OFS_STATUS, 32'h0000_0004, 32'h0000_0004);
        conv(24'h12_3456);
        rdc("clamped data", `AFC_OFS_DATA, 32'h00FF_FFFF);
        setcfg(32'h0000_000A);
        rdc("internal ref flag", `AFC_OFS_STATUS, 32'h0000_0000, 32'h0000_0004);
        setcfg(32'h0000_0000);
        rdc("check off flag", `AFC_OFS_STATUS, 32'h0000_0000, 32'h0000_0004);
        ref_low <= 1'b0;
        ref_open <= 1'b1;
        setcfg(32'h0000_0006);
        rdc("open ref flag", `AFC_OFS_STATUS, 32'h0000_0004, 32'h0000_0004);
        ref_open <= 1'b0;
    endtask
    task automatic t_cal();
        logic [7:0] dst;
        setcfg(32'h0000_0008);
        for (int m = 4; m < 8; m++)
        begin
            dst = m[0] ? `AFC_OFS_FULLSC : `AFC_OFS_OFFSET;
            wrm(m);
            repeat (2) @(posedge hclk);
            chk("cal start", {2'h3, m == 4, m == 5}, {mod_run, dout_rdy_o, cal_zero_int, cal_full_int});
            conv(24'h40_0000 + m[23:0]);
            rdc("coefficient", dst, 32'h0040_0000 + m);
            rdc("idle after cal", `AFC_OFS_MODE, 32'h0000_0002, 32'h0000_0007);
            chk("line low", 32'h0000_0001, {dout_rdy_o, dout_rdy_oe_n});
            rdc("ready", `AFC_OFS_STATUS, 32'h0000_0000, 32'h0000_0001);
        end
        wrm(32'h0000_000C);
        conv(24'h11_1111);
        rdc("chopped busy", `AFC_OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
        conv(24'h22_2222);
        rdc("chopped offset", `AFC_OFS_OFFSET, 32'h0022_2222);
    endtask
    task automatic t_calerr();
        ref_low <= 1'b1;
        setcfg(32'h0000_0002);
        wrm(32'h0000_0006);
        conv(24'h33_3333);
        rdc("cal error", `AFC_OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
        rdc("offset kept", `AFC_OFS_OFFSET, 32'h0022_2222);
        ref_low <= 1'b0;
        setcfg(32'h0000_0002);
        rdc("error held", `AFC_OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
        wrm(32'h0000_0001);
        conv(24'h80_0000);
        rdc("error cleared", `AFC_OFS_STATUS, 32'h0000_0000, 32'h0000_0002);
        setcfg(32'h0000_1C08);
        wrm(32'h0000_0005);
        rdc("gain 128 refused", `AFC_OFS_MODE, 32'h0000_0002, 32'h0000_0007);
        wrm(32'h0000_0007);
        rdc("system full kept", `AFC_OFS_MODE, 32'h0000_0007, 32'h0000_0007);
        conv(24'h70_0000);
    endtask
    task automatic t_serial();
        int base;
        setcfg(32'h0000_0041);
        base = n_modrst;
        host.send({1'b0, {31{1'b1}}, 1'b0, {31{1'b1}}}, 64);
        repeat (20) @(posedge hclk);
        chk("no serial reset", base, n_modrst);
        rdc("config kept", `AFC_OFS_CONFIG, 32'h0000_0041);
        host.send(64'h0000_0000_FFFF_FFFF, 32);
        repeat (20) @(posedge hclk);
        chk("serial reset pulse", base + 1, n_modrst);
        // host off the bus 500 us
        repeat (5000) @(posedge hclk);
        rdc("config cleared", `AFC_OFS_CONFIG, 32'h0000_0000);
        rdc("offset cleared", `AFC_OFS_OFFSET, 32'h0080_0000);
    endtask
    // main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        raw_valid = 1'b0;
        raw_data = 24'h00_0000;
        ref_low = 1'b0;
        ref_open = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_switch();
        t_conv();
        t_cal();
        t_calerr();
        t_serial();
        stop_test();
    end
endmodule
bind afc_frontend_ctrl afc_frontend_ctrl_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .hresp(hresp), .mod_reset(mod_reset), .cal_zero_int(cal_zero_int), .cal_full_int(cal_full_int),
    .burnout_source_en(burnout_source_en), .burnout_sink_en(burnout_sink_en), .excite_pin_a(excite_pin_a),
    .excite_pin_b(excite_pin_b), .excite_mag(excite_mag), .mid_supply_pair_en(mid_supply_pair_en),
    .ext_ref_pair_a(ext_ref_pair_a), .ext_ref_pair_b(ext_ref_pair_b), .int_ref_en(int_ref_en),
    .supply_monitor_en(supply_monitor_en));
